// ==== hdl/sop_cells_pkg.sv ====
// package: constants, register map and cell carrier type for the sum-of-products cells
package sop_cells_pkg;
	localparam int IN_PINS      = 8;
	localparam int CELLS        = 8;
	localparam int ARRAY_INPUTS = 16;
	localparam int PTERMS       = 64;
	localparam int PT_PER_CELL  = 8;
	localparam int LINES        = 2 * ARRAY_INPUTS;
	localparam int FUSES        = PTERMS * LINES;
	localparam int SYNC_STAGES  = 3;

	// product term slots inside one cell group
	localparam int SLOT_SUM0    = 0;
	localparam int SLOT_SUMS    = 4;
	localparam int SLOT_SET     = 4;
	localparam int SLOT_RESET   = 5;
	localparam int SLOT_CLOCK   = 6;
	localparam int SLOT_OE      = 7;

	// register map, byte addresses
	localparam logic [11:0] FUSE_BASE_ADDR = 12'h000;
	localparam logic [11:0] FUSE_LAST_ADDR = 12'h0FC;
	localparam logic [11:0] POLARITY_ADDR  = 12'h100;
	localparam logic [11:0] STATUS_ADDR    = 12'h104;

	// status field positions
	localparam int STATUS_REG_LSB = 0;
	localparam int STATUS_OUT_LSB = 8;
	localparam int STATUS_OE_LSB  = 16;

	// reset values: every fuse intact, every polarity connection intact
	localparam logic [31:0] FUSE_RESET     = 32'h0000_0000;
	localparam logic [7:0]  POLARITY_RESET = 8'h00;
	localparam logic [7:0]  CELLS_RESET    = 8'h00;
	localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

	typedef struct packed {
		logic sop;
		logic setTerm;
		logic resetTerm;
		logic clockTerm;
		logic oeTerm;
	} cell_ctl_t;

	typedef struct packed {
		logic [11:0] paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} apb_req_t;
endpackage : sop_cells_pkg

// ==== hdl/registered_sop_cells.sv ====
// registered sum-of-products array with eight output macro cells behind an APB fuse map
// What this block does
// - sixteen inputs, true and inverted, cross 64 product terms, 2048 fuse bits
// - product terms form eight groups of eight, one group per output macro cell
// - four terms of each group are ORed into the cell's sum-of-products
// - other four terms of a group are set, reset, clock and output enable
// - intact fuse connects an input phase; programmed fuse removes it
// - product term is true when every connected input phase is high
// - term connected to both phases of an input stays false; blank device all false
// - term with every fuse programmed stays true, and so does its function
// - set alone forces register one; output pin zero if polarity intact, one if removed
// - reset alone forces register zero; output pin one if polarity intact, zero if removed
// - set or reset override the cell clock; no edge changes register then
// - set and reset together bypass register; sum-of-products goes to output
// - each register clocked by its own group's clock product term
// - output driven only while control pin low and output-enable term true
// - per-output polarity xor; intact gives active-low, removed gives active-high
// - reset clears every cell register to zero before clocked operation
// - register captures sum-of-products on rising edge of its clock term
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module registered_sop_cells (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// apb slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// array pins
	input  wire logic [7:0]  inPins,
	input  wire logic        outCtlN,
	output logic      [7:0]  cellOut,
	output logic      [7:0]  cellOutEn
);
	localparam int NI = sop_cells_pkg::IN_PINS;
	localparam int NC = sop_cells_pkg::CELLS;

	sop_cells_pkg::apb_req_t  req;
	sop_cells_pkg::cell_ctl_t ctl [NC];

	logic [31:0]    fuse_ff [sop_cells_pkg::PTERMS];
	logic [NC-1:0]  polarity_ff;
	logic [NI-1:0]  inSync1_ff;
	logic [NI-1:0]  inSync2_ff;
	logic [NI-1:0]  inSync3_ff;
	logic [NI-1:0]  inStable_ff;
	logic           ctlSync1_ff;
	logic           ctlSync2_ff;
	logic           ctlSync3_ff;
	logic           ctlStable_ff;
	logic [NC-1:0]  cellReg_ff;
	logic [NC-1:0]  nxt_cellReg;
	logic [NC-1:0]  ptClkPrev_ff;
	logic [NC-1:0]  nxt_out;
	logic [NC-1:0]  nxt_outEn;
	logic [NC-1:0]  cellOut_ff;
	logic [NC-1:0]  cellOutEn_ff;
	logic [sop_cells_pkg::LINES-1:0]  lines;
	logic [sop_cells_pkg::PTERMS-1:0] pt;
	logic [31:0]    prdata_ff;
	logic [31:0]    nxt_prdata;
	logic           pslverr_ff;
	logic           nxt_pslverr;
	logic           accessPhase;
	logic           fuseHit;
	logic [5:0]     fuseIdx;

	// a product term: every line either removed by its fuse or high
	function automatic logic prodTerm(input logic [31:0] fuse, input logic [31:0] line);
		prodTerm = &(line | fuse);
	endfunction : prodTerm

	function automatic logic isFuseAddr(input logic [11:0] a);
		isFuseAddr = (a >= sop_cells_pkg::FUSE_BASE_ADDR) && (a <= sop_cells_pkg::FUSE_LAST_ADDR)
			&& (a[1:0] == 2'b00);
	endfunction : isFuseAddr

	function automatic logic isPolarityAddr(input logic [11:0] a);
		isPolarityAddr = (a == sop_cells_pkg::POLARITY_ADDR);
	endfunction : isPolarityAddr

	function automatic logic isStatusAddr(input logic [11:0] a);
		isStatusAddr = (a == sop_cells_pkg::STATUS_ADDR);
	endfunction : isStatusAddr

	// index of a slot inside cell c's group of eight product terms
	function automatic int termIdx(input int c, input int slot);
		termIdx = c * sop_cells_pkg::PT_PER_CELL + slot;
	endfunction : termIdx

	// output polarity stage; an intact connection (0) inverts
	function automatic logic toPin(input logic v, input logic blown);
		toPin = v ^ !blown;
	endfunction : toPin

	assign req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite, pwdata: pwdata};
	assign accessPhase = req.psel && req.penable;
	assign fuseHit = isFuseAddr(req.paddr);
	assign fuseIdx = req.paddr[7:2];

	// ---------------- apb register file ----------------
	// zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign prdata = prdata_ff;
	assign pslverr = pslverr_ff;

	// decoded in setup; a write reads back zero and status refuses writes
	always_comb begin
		nxt_prdata = sop_cells_pkg::READ_ZERO;
		nxt_pslverr = 1'b0;
		if (req.psel && !req.penable) begin
			if (fuseHit) begin
				nxt_prdata = fuse_ff[fuseIdx];
			end else if (isPolarityAddr(req.paddr)) begin
				nxt_prdata = {24'h00_0000, polarity_ff};
			end else if (isStatusAddr(req.paddr)) begin
				nxt_prdata[sop_cells_pkg::STATUS_REG_LSB +: NC] = cellReg_ff;
				nxt_prdata[sop_cells_pkg::STATUS_OUT_LSB +: NC] = cellOut_ff;
				nxt_prdata[sop_cells_pkg::STATUS_OE_LSB +: NC]  = cellOutEn_ff;
			end else begin
				nxt_pslverr = 1'b1;
			end
			if (req.pwrite) begin
				nxt_prdata = sop_cells_pkg::READ_ZERO;
			end
			if (req.pwrite && isStatusAddr(req.paddr)) begin
				nxt_pslverr = 1'b1;
			end
		end
	end

	// read data and error are prepared in setup so they stand through the access cycle
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			prdata_ff <= sop_cells_pkg::READ_ZERO;
			pslverr_ff <= 1'b0;
		end else if (req.psel && !req.penable) begin
			prdata_ff <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// one word per product term, line 2k is input k true, 2k+1 its complement
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			for (int i = 0; i < sop_cells_pkg::PTERMS; i++) begin
				fuse_ff[i] <= sop_cells_pkg::FUSE_RESET;
			end
		end else if (accessPhase && req.pwrite && fuseHit) begin
			fuse_ff[fuseIdx] <= req.pwdata;
		end
	end

	// reset leaves every connection intact, so all outputs start active-low
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			polarity_ff <= sop_cells_pkg::POLARITY_RESET;
		end else if (accessPhase && req.pwrite && isPolarityAddr(req.paddr)) begin
			polarity_ff <= req.pwdata[NC-1:0];
		end
	end

	// ---------------- pin synchronisers ----------------
	// a level counts only once stages two and three agree, so a one-cycle runt never reaches the array
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			inSync1_ff <= '0;
			inSync2_ff <= '0;
			inSync3_ff <= '0;
			inStable_ff <= '0;
		end else begin
			inSync1_ff <= inPins;
			inSync2_ff <= inSync1_ff;
			inSync3_ff <= inSync2_ff;
			for (int k = 0; k < NI; k++) begin
				if (inSync2_ff[k] == inSync3_ff[k]) begin
					inStable_ff[k] <= inSync3_ff[k];
				end
			end
		end
	end

	// control resets high so no output drives before the pin has been seen
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ctlSync1_ff <= 1'b1;
			ctlSync2_ff <= 1'b1;
			ctlSync3_ff <= 1'b1;
			ctlStable_ff <= 1'b1;
		end else begin
			ctlSync1_ff <= outCtlN;
			ctlSync2_ff <= ctlSync1_ff;
			ctlSync3_ff <= ctlSync2_ff;
			if (ctlSync2_ff == ctlSync3_ff) begin
				ctlStable_ff <= ctlSync3_ff;
			end
		end
	end

	// ---------------- and array ----------------
	// inputs 0..7 are pins, 8..15 are cell feedback; registered so no loop forms
	always_comb begin
		for (int k = 0; k < sop_cells_pkg::ARRAY_INPUTS; k++) begin
			if (k < NI) begin
				lines[2*k] = inStable_ff[k];
				lines[2*k+1] = !inStable_ff[k];
			end else begin
				lines[2*k] = cellOut_ff[k-NI];
				lines[2*k+1] = !cellOut_ff[k-NI];
			end
		end
	end

	// both phases left connected can never both be high, so the term is false
	always_comb begin
		for (int p = 0; p < sop_cells_pkg::PTERMS; p++) begin
			pt[p] = prodTerm(fuse_ff[p], lines);
		end
	end

	// ---------------- output macro cells ----------------
	always_comb begin
		for (int c = 0; c < NC; c++) begin
			ctl[c].sop = |pt[termIdx(c, sop_cells_pkg::SLOT_SUM0) +: sop_cells_pkg::SLOT_SUMS];
			ctl[c].setTerm = pt[termIdx(c, sop_cells_pkg::SLOT_SET)];
			ctl[c].resetTerm = pt[termIdx(c, sop_cells_pkg::SLOT_RESET)];
			ctl[c].clockTerm = pt[termIdx(c, sop_cells_pkg::SLOT_CLOCK)];
			ctl[c].oeTerm = pt[termIdx(c, sop_cells_pkg::SLOT_OE)];
		end
	end

	// set and reset act as levels; the clock term only by its rising edge
	always_comb begin
		for (int c = 0; c < NC; c++) begin
			nxt_cellReg[c] = cellReg_ff[c];
			if (ctl[c].setTerm && !ctl[c].resetTerm) begin
				nxt_cellReg[c] = 1'b1;
			end else if (ctl[c].resetTerm && !ctl[c].setTerm) begin
				nxt_cellReg[c] = 1'b0;
			end else if (!ctl[c].setTerm && ctl[c].clockTerm && !ptClkPrev_ff[c]) begin
				nxt_cellReg[c] = ctl[c].sop;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cellReg_ff <= sop_cells_pkg::CELLS_RESET;
		end else begin
			cellReg_ff <= nxt_cellReg;
		end
	end

	// blank terms are false, so clearing the history cannot fake a first clock edge
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ptClkPrev_ff <= '0;
		end else begin
			for (int c = 0; c < NC; c++) begin
				ptClkPrev_ff[c] <= ctl[c].clockTerm;
			end
		end
	end

	// polarity bit 0 (intact) inverts, so a set register drives the pin low
	always_comb begin
		for (int c = 0; c < NC; c++) begin
			if (ctl[c].setTerm && ctl[c].resetTerm) begin
				nxt_out[c] = toPin(ctl[c].sop, polarity_ff[c]);
			end else begin
				nxt_out[c] = toPin(nxt_cellReg[c], polarity_ff[c]);
			end
			nxt_outEn[c] = !ctlStable_ff && ctl[c].oeTerm;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cellOut_ff <= ~sop_cells_pkg::CELLS_RESET;
		end else begin
			cellOut_ff <= nxt_out;
		end
	end

	// enables clear in reset so nothing drives until terms and control pin allow it
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cellOutEn_ff <= '0;
		end else begin
			cellOutEn_ff <= nxt_outEn;
		end
	end

	assign cellOut = cellOut_ff;
	assign cellOutEn = cellOutEn_ff;
endmodule : registered_sop_cells

// ==== testbench/sop_cells_checker.sv ====
// port checks for the sum-of-products cells
`timescale 1ns/1ps
module sop_cells_checker (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        resetn,
	// apb
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pins
	input wire logic        outCtlN,
	input wire logic [7:0]  cellOut,
	input wire logic [7:0]  cellOutEn
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence bad_s;
		setup_s ##0 (paddr > sop_cells_pkg::STATUS_ADDR || paddr[1:0] != 2'b00);
	endsequence
	chk_ready_always: assert property (pready)
		else $error("pready low");
	chk_unmapped_err: assert property (bad_s |=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");
	chk_status_ro: assert property (setup_s ##0 (pwrite && paddr == sop_cells_pkg::STATUS_ADDR) |=> pslverr)
		else $error("status write not refused");
	chk_mapped_ok: assert property (setup_s ##0 (paddr < sop_cells_pkg::STATUS_ADDR && paddr[1:0] == 2'b00)
		|=> !pslverr)
		else $error("mapped access refused");
	chk_rdata_stands: assert property (psel && penable |=> $stable(prdata))
		else $error("read data moved after access");
	chk_status_mirror: assert property (setup_s ##0 (!pwrite && paddr == sop_cells_pkg::STATUS_ADDR)
		|=> prdata[15:8] == $past(cellOut) && prdata[23:16] == $past(cellOutEn))
		else $error("status does not mirror pins");
	chk_ctl_disables: assert property (outCtlN [*8] |-> cellOutEn == 8'h00)
		else $error("output enabled while control pin high");
	chk_reset_pins: assert property ($rose(resetn) |-> cellOut == 8'hFF && cellOutEn == 8'h00)
		else $error("pins wrong after reset");
endmodule : sop_cells_checker

// ==== testbench/board_model.sv ====
// board around the cells: drives array pins, pulls released outputs high
`timescale 1ns/1ps
module board_model (
	// cell side
	input  wire logic       ref_clk,
	input  wire logic [7:0] cellOut,
	input  wire logic [7:0] cellOutEn,
	output logic      [7:0] inPins,
	output logic            outCtlN,
	output logic      [7:0] pinLevel
);
	initial begin
		inPins  = 8'h00;
		outCtlN = 1'b0;
	end
	// a released pin shows its pull-up, never the last driven value
	always_comb pinLevel = (cellOut & cellOutEn) | ~cellOutEn;
	task automatic drive(input logic [7:0] v, input logic c);
		@(posedge ref_clk);
		inPins  <= v;
		outCtlN <= c;
	endtask : drive
endmodule : board_model

// ==== testbench/tb_registered_sop_cells.sv ====
// self-checking bench for the sum-of-products cells
`timescale 1ns/1ps
module tb_registered_sop_cells;
	logic        ref_clk = 1'b0;
	logic        resetn  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [31:0] pwdata  = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  inPins;
	logic        outCtlN;
	logic [7:0]  cellOut;
	logic [7:0]  cellOutEn;
	logic [7:0]  pinLevel;
	int          failures = 0;
	int          nTests   = 0;
	always #10 ref_clk = ~ref_clk;
	registered_sop_cells registered_sop_cells_i (.ref_clk(ref_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.inPins(inPins), .outCtlN(outCtlN), .cellOut(cellOut), .cellOutEn(cellOutEn));
	board_model board_model_i (.ref_clk(ref_clk), .cellOut(cellOut), .cellOutEn(cellOutEn), .inPins(inPins),
		.outCtlN(outCtlN), .pinLevel(pinLevel));
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", nTests, failures);
		if (failures == 0 && nTests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [31:0] ed,
		input logic ee);
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		if (!w) chk("prdata", prdata, ed);
		chk("pslverr", 32'(pslverr), 32'(ee));
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wf(input int t, input logic [31:0] v);
		xfer(12'(4 * t), 1'b1, v, 32'h0000_0000, 1'b0);
	endtask : wf
	// pins settle within five edges after a term change
	task automatic pin(input logic [7:0] o, input logic [7:0] e);
		repeat (8) @(posedge ref_clk);
		chk("cellOut", 32'(cellOut), 32'(o));
		chk("cellOutEn", 32'(cellOutEn), 32'(e));
	endtask : pin
	initial begin
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		pin(8'hFF, 8'h00);
		xfer(12'h104, 1'b0, 32'h0000_0000, 32'h0000_FF00, 1'b0);
		xfer(12'h100, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0);
		xfer(12'h108, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b1);
		xfer(12'h104, 1'b1, 32'h0000_0001, 32'h0000_0000, 1'b1);
		xfer(12'h002, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b1);
		xfer(12'h0FC, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0);
		wf(62, 32'h1234_5678);
		xfer(12'h0F8, 1'b0, 32'h0000_0000, 32'h1234_5678, 1'b0);
		wf(7, 32'hFFFF_FFFF);
		pin(8'hFF, 8'h01);
		board_model_i.drive(8'h00, 1'b1);
		pin(8'hFF, 8'h00);
		chk("pinLevel", 32'(pinLevel), 32'h0000_00FF);
		board_model_i.drive(8'h00, 1'b0);
		wf(0, 32'hFFFF_FFFF);
		wf(6, 32'hFFFF_FFFE);
		pin(8'hFF, 8'h01);
		board_model_i.drive(8'h01, 1'b0);
		pin(8'hFE, 8'h01);
		xfer(12'h104, 1'b0, 32'h0000_0000, 32'h0001_FE01, 1'b0);
		wf(15, 32'hFFFD_FFFF);
		pin(8'hFE, 8'h03);
		wf(5, 32'hFFFF_FFFF);
		pin(8'hFF, 8'h01);
		xfer(12'h104, 1'b0, 32'h0000_0000, 32'h0001_FF00, 1'b0);
		board_model_i.drive(8'h00, 1'b0);
		pin(8'hFF, 8'h01);
		board_model_i.drive(8'h01, 1'b0);
		pin(8'hFF, 8'h01);
		wf(4, 32'hFFFF_FFFF);
		pin(8'hFE, 8'h03);
		wf(0, 32'h0000_0000);
		pin(8'hFF, 8'h01);
		xfer(12'h100, 1'b1, 32'h0000_0001, 32'h0000_0000, 1'b0);
		pin(8'hFE, 8'h03);
		xfer(12'h100, 1'b0, 32'h0000_0000, 32'h0000_0001, 1'b0);
		xfer(12'h100, 1'b1, 32'h0000_0000, 32'h0000_0000, 1'b0);
		wf(5, 32'h0000_0000);
		pin(8'hFE, 8'h03);
		xfer(12'h104, 1'b0, 32'h0000_0000, 32'h0003_FE01, 1'b0);
		tally_and_finish();
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		failures++;
		tally_and_finish();
	end
endmodule : tb_registered_sop_cells
bind registered_sop_cells sop_cells_checker sop_cells_checker_i (.ref_clk(ref_clk), .resetn(resetn),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .outCtlN(outCtlN), .cellOut(cellOut), .cellOutEn(cellOutEn));
